//--- inc/prog_port_cfg.svh
/*
  Constants of the serial program/verify port: command codes, frame lengths,
  memory map figures and timing counts.
  Assumes inclusion by bare name from the design modules and the bench files.
*/
`ifndef PROG_PORT_CFG_SVH
`define PROG_PORT_CFG_SVH

// ****************************************************************
// Command codes (low four bits of the six-bit command)
// ****************************************************************
`define CMD_LOAD 4'h2
`define CMD_READ 4'h4
`define CMD_INCREMENT 4'h6
`define CMD_BEGIN_PROG 4'h8
`define CMD_END_PROG 4'hE
`define CMD_BULK_ERASE 4'h9

// ****************************************************************
// Frame lengths in serial clocks
// ****************************************************************
`define CMD_CLOCKS 6
`define DATA_CLOCKS 16
`define DATA_BITS 14

// ****************************************************************
// Memory map
// ****************************************************************
`define SMALL_LAST_ADDR 11'h3FF
`define LARGE_LAST_ADDR 11'h7FF
`define SMALL_CFG_BASE 11'h200
`define LARGE_CFG_BASE 11'h400
`define CFG_IMPL_WORDS 64
`define USER_ID_WORDS 4
`define BACKUP_CAL_INDEX 4
`define PROTECT_LOW_ADDR 11'h040
`define CODE_PROTECT_BIT 3
`define ERASED_WORD 12'hFFF

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS 50
`define ERASE_TIME_US 100
`define ERASE_CYCLES ((`ERASE_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- inc/prog_port_pkg.sv
/*
  Types shared by the serial program/verify port modules.
  Assumes the constants header is on the include path.
*/
package prog_port_pkg;

  // ****************************************************************
  // State encodings
  // ****************************************************************
  typedef enum logic {
    LINK_CMD = 1'b0,
    LINK_DATA = 1'b1
  } link_state_t;

  typedef enum logic [1:0] {
    CORE_IDLE = 2'b00,
    CORE_PROGRAMMING = 2'b01,
    CORE_ERASING = 2'b11
  } core_state_t;

endpackage : prog_port_pkg

//--- hdl/prog_serial_link.sv
/*
  Link end of the serial program/verify port: shifts commands and data on the
  programmer's serial clock and drives the shared data pin during reads.
  Assumes the serial clock only runs inside frames and that linkReset is held
  whenever program/verify mode is not active.
*/
`timescale 1ns/1ps
`include "prog_port_cfg.svh"

module prog_serial_link
  import prog_port_pkg::*;
(
  input wire logic linkClk,
  input wire logic linkReset,
  input wire logic serialIn,
  input wire logic [11:0] readWord,
  output logic serialOut,
  output logic serialOe,
  output logic cmdToggle,
  output logic [3:0] cmdCode,
  output logic [13:0] cmdData
);

  link_state_t state_reg;
  logic [4:0] bitCount_reg;
  logic [5:0] cmdShift_reg;
  logic [13:0] dataShift_reg;
  logic isRead_reg;
  logic [4:0] riseCount_reg;
  logic [13:0] outShift_reg;
  logic [5:0] cmdShiftNext;

  assign cmdShiftNext = {serialIn, cmdShift_reg[5:1]};

  // ****************************************************************
  // Falling-edge capture of commands and data
  // ****************************************************************
  always_ff @(negedge linkClk or posedge linkReset) begin
    if (linkReset) begin
      state_reg <= LINK_CMD;
      bitCount_reg <= 5'h00;
      cmdShift_reg <= 6'h00;
      dataShift_reg <= 14'h0000;
      isRead_reg <= 1'b0;
      cmdCode <= 4'h0;
      cmdData <= 14'h0000;
      cmdToggle <= 1'b0;
    end else begin
      case (state_reg)
        LINK_CMD: begin
          cmdShift_reg <= cmdShiftNext;
          if (bitCount_reg == 5'(`CMD_CLOCKS - 1)) begin
            bitCount_reg <= 5'h00;
            cmdCode <= cmdShiftNext[3:0];
            if (cmdShiftNext[3:0] == `CMD_LOAD || cmdShiftNext[3:0] == `CMD_READ) begin
              state_reg <= LINK_DATA;
              isRead_reg <= (cmdShiftNext[3:0] == `CMD_READ);
            end else begin
              cmdToggle <= ~cmdToggle;
            end
          end else begin
            bitCount_reg <= bitCount_reg + 5'h01;
          end
        end
        LINK_DATA: begin
          if (bitCount_reg != 5'h00 && bitCount_reg != 5'(`DATA_CLOCKS - 1)) begin
            dataShift_reg <= {serialIn, dataShift_reg[13:1]};
          end
          if (bitCount_reg == 5'(`DATA_CLOCKS - 1)) begin
            bitCount_reg <= 5'h00;
            state_reg <= LINK_CMD;
            if (!isRead_reg) begin
              cmdData <= dataShift_reg;
              cmdToggle <= ~cmdToggle;
            end
          end else begin
            bitCount_reg <= bitCount_reg + 5'h01;
          end
        end
        default: begin
          state_reg <= LINK_CMD;
        end
      endcase
    end
  end

  // ****************************************************************
  // Rising-edge drive of read data
  // ****************************************************************
  always_ff @(posedge linkClk or posedge linkReset) begin
    if (linkReset) begin
      riseCount_reg <= 5'h00;
      outShift_reg <= 14'h0000;
      serialOut <= 1'b0;
      serialOe <= 1'b0;
    end else if (state_reg == LINK_DATA && isRead_reg) begin
      riseCount_reg <= riseCount_reg + 5'h01;
      if (riseCount_reg == 5'h01) begin
        serialOe <= 1'b1;
        serialOut <= readWord[0];
        outShift_reg <= {3'h0, readWord[11:1]};
      end else if (riseCount_reg == 5'(`DATA_CLOCKS - 1)) begin
        serialOe <= 1'b0;
        serialOut <= 1'b0;
      end else if (riseCount_reg > 5'h01) begin
        serialOut <= outShift_reg[0];
        outShift_reg <= {1'b0, outShift_reg[13:1]};
      end
    end else begin
      riseCount_reg <= 5'h00;
      serialOe <= 1'b0;
      serialOut <= 1'b0;
    end
  end

endmodule : prog_serial_link

//--- hdl/serial_program_verify_port.sv
/*
  Program/verify port of a small 12-bit-core controller: mode entry, program
  counter, user and configuration memory, and command execution.
  Assumes a free-running clk, an asynchronous reset, a level input that is high
  while the programming voltage is applied, and an external programmer that
  respects the minimum delay between command and data segment.
*/
`timescale 1ns/1ps
`include "prog_port_cfg.svh"

// Notes on behaviour
// - Entering the mode holds all other logic in reset, pins high impedance.
// - Mode entry presets the counter to the configuration word address.
// - Program space is user memory below, configuration memory above.
// - Counter runs from last user address into configuration base, not zero.
// - Sixty-four configuration words exist; only four user ID words usable.
// - User ID words read true contents even under code protection.
// - Configuration word reachable only until the first increment command.
// - Bulk erase keeps backup calibration unless counter was in configuration memory past the open configuration word.
// - Six-bit commands, top two bits ignored, begin, end and increment codes.
// - Load command is followed by start, fourteen data bits, stop.
// - Read command returns the addressed word in a sixteen-clock segment.
// - Bulk erase is internally timed and needs no end command.
// - Increment advances the counter by one and has no data segment.
// - Commands are six clocks, LSb first, latched on falling edges.
// - Data segment is sixteen clocks; start and stop values ignored.
// - Read drives the pin from rising edge two, releases at sixteen.
// - Upper two loaded bits are ignored and read back as zero.
module serial_program_verify_port
  import prog_port_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b0
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic master_clear_input,
  input wire logic prog_serial_clock,
  input wire logic prog_serial_data_in,
  output logic prog_serial_data_out,
  output logic prog_serial_data_oe,
  output logic otherLogicReset,
  output logic progModeActive,
  output logic programBusy,
  output logic eraseBusy
);

  // ****************************************************************
  // Map figures for the chosen variant
  // ****************************************************************
  localparam logic [10:0] LAST_ADDR = LARGE_VARIANT ? `LARGE_LAST_ADDR : `SMALL_LAST_ADDR;
  localparam logic [10:0] CFG_BASE = LARGE_VARIANT ? `LARGE_CFG_BASE : `SMALL_CFG_BASE;
  localparam int USER_WORDS = LARGE_VARIANT ? 1024 : 512;
  localparam logic [11:0] ERASE_LAST = 12'(`ERASE_CYCLES - 1);

  function automatic logic inConfigSpace(input logic [10:0] addr);
    inConfigSpace = (addr >= CFG_BASE);
  endfunction : inConfigSpace

  function automatic logic [10:0] configOffset(input logic [10:0] addr);
    configOffset = addr - CFG_BASE;
  endfunction : configOffset

  function automatic logic [10:0] pcIncrement(input logic [10:0] addr);
    pcIncrement = (addr + 11'h001) & LAST_ADDR;
  endfunction : pcIncrement

  // ****************************************************************
  // Mode entry
  // ****************************************************************
  logic modeReqMeta_reg;
  logic modeReqSync_reg;
  logic progMode_reg;
  logic modeEntry;
  logic linkReset;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      modeReqMeta_reg <= 1'b0;
      modeReqSync_reg <= 1'b0;
      progMode_reg <= 1'b0;
    end else begin
      modeReqMeta_reg <= master_clear_input;
      modeReqSync_reg <= modeReqMeta_reg;
      progMode_reg <= modeReqSync_reg;
    end
  end

  assign modeEntry = modeReqSync_reg && !progMode_reg;
  // The link end stays in reset outside the mode, so a stray pin edge cannot start a frame.
  assign linkReset = ~progMode_reg;

  // rest of the device held in reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      otherLogicReset <= 1'b0;
      progModeActive <= 1'b0;
    end else begin
      otherLogicReset <= modeReqSync_reg;
      progModeActive <= modeReqSync_reg;
    end
  end

  // ****************************************************************
  // Link end and command crossing
  // ****************************************************************
  logic cmdToggle;
  logic [3:0] cmdCode;
  logic [13:0] cmdData;
  logic [11:0] readWord_reg;
  logic tglMeta_reg;
  logic tglSync_reg;
  logic tglSeen_reg;
  logic cmdEvent;

  prog_serial_link link (
    .linkClk(prog_serial_clock),
    .linkReset(linkReset),
    .serialIn(prog_serial_data_in),
    .readWord(readWord_reg),
    .serialOut(prog_serial_data_out),
    .serialOe(prog_serial_data_oe),
    .cmdToggle(cmdToggle),
    .cmdCode(cmdCode),
    .cmdData(cmdData)
  );

  // Code and data stay still from the toggle until the next command frame ends,
  // which the programmer's inter-command delay keeps far beyond this sync latency.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tglMeta_reg <= 1'b0;
      tglSync_reg <= 1'b0;
      tglSeen_reg <= 1'b0;
    end else if (!progMode_reg) begin
      tglMeta_reg <= 1'b0;
      tglSync_reg <= 1'b0;
      tglSeen_reg <= 1'b0;
    end else begin
      tglMeta_reg <= cmdToggle;
      tglSync_reg <= tglMeta_reg;
      tglSeen_reg <= tglSync_reg;
    end
  end

  assign cmdEvent = progMode_reg && (tglSync_reg ^ tglSeen_reg);

  // ****************************************************************
  // Program counter and command execution
  // ****************************************************************
  core_state_t state_reg;
  logic [10:0] pc_reg;
  logic incSeen_reg;
  logic [11:0] loadWord_reg;
  logic [11:0] eraseCount_reg;
  logic eraseConfig_reg;
  logic configWordOpen;

  // config word only before any increment
  assign configWordOpen = (pc_reg == LAST_ADDR) && !incSeen_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= CORE_IDLE;
      pc_reg <= 11'h000;
      incSeen_reg <= 1'b0;
      loadWord_reg <= 12'h000;
      eraseCount_reg <= 12'h000;
      eraseConfig_reg <= 1'b0;
    end else if (modeEntry) begin
      state_reg <= CORE_IDLE;
      pc_reg <= LAST_ADDR;
      incSeen_reg <= 1'b0;
    end else if (!progMode_reg) begin
      // Leaving the mode abandons any programming or erase in progress.
      state_reg <= CORE_IDLE;
    end else if (state_reg == CORE_ERASING) begin
      // erase ends on its own timer
      if (eraseCount_reg == ERASE_LAST) begin
        state_reg <= CORE_IDLE;
      end else begin
        eraseCount_reg <= eraseCount_reg + 12'h001;
      end
    end else if (cmdEvent) begin
      case (cmdCode)
        `CMD_LOAD: begin
          loadWord_reg <= cmdData[11:0];
        end
        `CMD_INCREMENT: begin
          pc_reg <= pcIncrement(pc_reg);
          incSeen_reg <= 1'b1;
        end
        `CMD_BEGIN_PROG: begin
          state_reg <= CORE_PROGRAMMING;
        end
        `CMD_END_PROG: begin
          state_reg <= CORE_IDLE;
        end
        `CMD_BULK_ERASE: begin
          state_reg <= CORE_ERASING;
          eraseCount_reg <= 12'h000;
          eraseConfig_reg <= inConfigSpace(pc_reg) && !configWordOpen;
        end
        default: begin
          state_reg <= state_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      programBusy <= 1'b0;
      eraseBusy <= 1'b0;
    end else begin
      programBusy <= modeReqSync_reg && (state_reg == CORE_PROGRAMMING);
      eraseBusy <= modeReqSync_reg && (state_reg == CORE_ERASING);
    end
  end

  // ****************************************************************
  // Nonvolatile storage
  // ****************************************************************
  logic [11:0] userMem [0:1023];
  logic [11:0] cfgMem [0:`CFG_IMPL_WORDS-1];
  logic [11:0] configWord_reg;
  logic [10:0] pcOffset;
  logic [10:0] eraseCfgIdx;
  logic beginWrite;

  assign pcOffset = configOffset(pc_reg);
  assign eraseCfgIdx = 11'(eraseCount_reg) - 11'(USER_WORDS);
  assign beginWrite = cmdEvent && (cmdCode == `CMD_BEGIN_PROG) && (state_reg != CORE_ERASING) && !modeEntry;

  // Storage keeps its contents over reset, as the cells would.
  // Programming only clears bits; an erase is needed to set them again.
  always_ff @(posedge clk) begin
    if (beginWrite) begin
      if (!inConfigSpace(pc_reg)) begin
        userMem[pc_reg[9:0]] <= userMem[pc_reg[9:0]] & loadWord_reg;
      end else if (configWordOpen) begin
        configWord_reg <= configWord_reg & loadWord_reg;
      end else if (pcOffset <= 11'(`BACKUP_CAL_INDEX)) begin
        cfgMem[pcOffset[5:0]] <= cfgMem[pcOffset[5:0]] & loadWord_reg;
      end
    end else if (state_reg == CORE_ERASING) begin
      if (eraseCount_reg == 12'h000) begin
        configWord_reg <= `ERASED_WORD;
      end
      if (eraseCount_reg < 12'(USER_WORDS)) begin
        userMem[eraseCount_reg[9:0]] <= `ERASED_WORD;
      end else if (eraseConfig_reg && eraseCfgIdx < 11'(`CFG_IMPL_WORDS)) begin
        cfgMem[eraseCfgIdx[5:0]] <= `ERASED_WORD;
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic codeProtected;

  assign codeProtected = !configWord_reg[`CODE_PROTECT_BIT];

  // The word is refreshed every cycle so it is long settled before the link samples it.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readWord_reg <= 12'h000;
    end else if (!inConfigSpace(pc_reg)) begin
      if (codeProtected && pc_reg >= `PROTECT_LOW_ADDR && pc_reg != CFG_BASE - 11'h001) begin
        readWord_reg <= 12'h000;
      end else begin
        readWord_reg <= userMem[pc_reg[9:0]];
      end
    end else if (configWordOpen) begin
      readWord_reg <= configWord_reg;
    end else if (pcOffset < 11'(`CFG_IMPL_WORDS)) begin
      readWord_reg <= cfgMem[pcOffset[5:0]];
    end else begin
      readWord_reg <= 12'h000;
    end
  end

endmodule : serial_program_verify_port

//--- tb/prog_port_monitor.sv
/*
  Checker for the serial program/verify port, bound to its top module.
  Assumes it sees only the top module's ports, all sampled on clk.
*/
`timescale 1ns/1ps

module prog_port_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic master_clear_input,
  input wire logic prog_serial_data_out,
  input wire logic prog_serial_data_oe,
  input wire logic otherLogicReset,
  input wire logic progModeActive,
  input wire logic programBusy,
  input wire logic eraseBusy
);
  // ****
  // Pulse width counters
  // ****
  logic [11:0] eraseCnt;
  logic [5:0] oeCnt;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      eraseCnt <= 12'h000;
    end else begin
      eraseCnt <= eraseBusy ? eraseCnt + 12'h001 : 12'h000;
    end
  end

  // The pin window is 14 serial clocks; the two clocks are unrelated, so two cycles either way.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oeCnt <= 6'h00;
    end else begin
      oeCnt <= prog_serial_data_oe ? oeCnt + 6'h01 : 6'h00;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ****
  // Assertions
  // ****
  mode_holds_reset_a: assert property (otherLogicReset == $past(master_clear_input, 3))
    else $error("other-logic reset does not follow the mode request");
  mode_entry_a: assert property ($rose(master_clear_input) |-> ##[1:4] progModeActive)
    else $error("mode not entered after mode request");
  mode_exit_a: assert property ($fell(master_clear_input) |-> ##[1:4] !progModeActive)
    else $error("mode not left after request dropped");
  pin_needs_mode_a: assert property (prog_serial_data_oe |-> progModeActive)
    else $error("data pin driven outside the mode");
  idle_out_low_a: assert property (!prog_serial_data_oe |-> !prog_serial_data_out)
    else $error("data out not low while released");
  read_window_a: assert property ($fell(prog_serial_data_oe) |-> oeCnt inside {[6'd33:6'd37]})
    else $error("read drive window has wrong length");
  erase_length_a: assert property ($fell(eraseBusy) |-> eraseCnt inside {[12'd1998:12'd2002]})
    else $error("erase busy has wrong length");
  busy_exclusive_a: assert property (!(programBusy && eraseBusy))
    else $error("programming and erase busy together");
  busy_needs_mode_a: assert property (!progModeActive |-> !programBusy && !eraseBusy)
    else $error("busy flag outside the mode");
  erase_no_drive_a: assert property (eraseBusy |-> !prog_serial_data_oe)
    else $error("data pin driven during erase");

  cover property ($fell(prog_serial_data_oe));
  cover property ($fell(eraseBusy));
  cover property ($fell(programBusy));
endmodule : prog_port_monitor

bind serial_program_verify_port prog_port_monitor i_monitor (
  .clk(clk), .reset(reset), .master_clear_input(master_clear_input),
  .prog_serial_data_out(prog_serial_data_out), .prog_serial_data_oe(prog_serial_data_oe),
  .otherLogicReset(otherLogicReset), .progModeActive(progModeActive),
  .programBusy(programBusy), .eraseBusy(eraseBusy)
);

//--- tb/prog_programmer_model.sv
/*
  Behavioural external programmer: mode request, serial clock and data.
  Assumes the bench resolves the shared data line and feeds it back.
*/
`timescale 1ns/1ps
`include "prog_port_cfg.svh"

module prog_programmer_model (
  input wire logic clk,
  input wire logic dataLine,
  output logic serialClock,
  output logic dataDrive,
  output logic dataOe,
  output logic modeRequest
);
  localparam real HALF_NS = 62.5;
  localparam real GAP_NS = 250.0;

  initial begin
    serialClock = 1'b0;
    dataDrive = 1'b0;
    dataOe = 1'b1;
    modeRequest = 1'b0;
  end

  task automatic enter_mode();
    @(negedge clk);
    serialClock = 1'b0;
    dataDrive = 1'b0;
    dataOe = 1'b1;
    modeRequest = 1'b0;
    repeat (6) @(negedge clk);
    modeRequest = 1'b1;
    repeat (6) @(negedge clk);
  endtask : enter_mode

  task automatic pulse(input logic bitVal);
    dataDrive = bitVal;
    serialClock = 1'b1;
    #(HALF_NS);
    serialClock = 1'b0;
    #(HALF_NS);
  endtask : pulse

  task automatic send_cmd(input logic [5:0] code);
    for (int i = 0; i < 6; i++) begin
      pulse(code[i]);
    end
    #(GAP_NS);
  endtask : send_cmd

  task automatic send_load(input logic [13:0] word);
    logic [15:0] frame;
    frame = {1'b0, word, 1'b0};
    for (int i = 0; i < 16; i++) begin
      pulse(frame[i]);
    end
    #(GAP_NS);
  endtask : send_load

  task automatic read_word(output logic [13:0] word);
    send_cmd({2'b11, `CMD_READ});
    dataOe = 1'b0;
    for (int i = 0; i < 16; i++) begin
      serialClock = 1'b1;
      #(HALF_NS);
      if (i >= 1 && i <= 14) begin
        word[i - 1] = dataLine;
      end
      serialClock = 1'b0;
      #(HALF_NS);
    end
    dataOe = 1'b1;
    #(GAP_NS);
  endtask : read_word
endmodule : prog_programmer_model

//--- tb/serial_program_verify_port_tb.sv
/*
  Self-checking bench for the serial program/verify port, small variant.
  Assumes the programmer model drives the serial side at 125 ns per clock.
*/
`timescale 1ns/1ps
`include "prog_port_cfg.svh"

module serial_program_verify_port_tb;
  logic clk;
  logic reset;
  logic serialClock, progDrive, progOe, modeRequest;
  logic dataOut, dataOe, otherLogicReset, progModeActive, programBusy, eraseBusy;
  logic floatBit = 1'b0;
  logic dataLine;
  int n_mismatch = 0;
  int n_checks = 0;

  // A released line must not look like a stable value, so it toggles every cycle.
  always @(posedge clk) floatBit <= ~floatBit;
  assign dataLine = dataOe ? dataOut : (progOe ? progDrive : floatBit);

  serial_program_verify_port #(.LARGE_VARIANT(1'b0)) i_dut (
    .clk(clk), .reset(reset), .master_clear_input(modeRequest), .prog_serial_clock(serialClock),
    .prog_serial_data_in(dataLine), .prog_serial_data_out(dataOut), .prog_serial_data_oe(dataOe),
    .otherLogicReset(otherLogicReset), .progModeActive(progModeActive),
    .programBusy(programBusy), .eraseBusy(eraseBusy)
  );

  prog_programmer_model i_prog (
    .clk(clk), .dataLine(dataLine), .serialClock(serialClock), .dataDrive(progDrive),
    .dataOe(progOe), .modeRequest(modeRequest)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****
  // Shared tasks
  // ****
  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [13:0] expVal, input logic [13:0] gotVal);
    n_checks++;
    if (gotVal !== expVal) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, expVal, gotVal);
    end
  endtask : check

  task automatic inc_n(input int n);
    repeat (n) i_prog.send_cmd({2'b10, `CMD_INCREMENT});
  endtask : inc_n

  task automatic read_expect(input string what, input logic [13:0] expVal);
    logic [13:0] word;
    i_prog.read_word(word);
    check(what, expVal, word);
    check("pin drive after read", 14'h0000, {13'h0000, dataOe});
  endtask : read_expect

  task automatic program_word(input logic [13:0] word);
    i_prog.send_cmd({2'b01, `CMD_LOAD});
    i_prog.send_load(word);
    i_prog.send_cmd({2'b00, `CMD_BEGIN_PROG});
    check("busy after begin", 14'h0001, {13'h0000, programBusy});
    i_prog.send_cmd({2'b11, `CMD_END_PROG});
    check("busy after end", 14'h0000, {13'h0000, programBusy});
  endtask : program_word

  // A command sent during the erase must be dropped by the device.
  task automatic erase_wait(input bit sendDuring);
    int k;
    i_prog.send_cmd({2'b00, `CMD_BULK_ERASE});
    for (k = 0; k < 20 && eraseBusy !== 1'b1; k++) @(negedge clk);
    check("erase started", 14'h0001, {13'h0000, eraseBusy});
    if (sendDuring) begin
      inc_n(1);
    end
    for (k = 0; k < 2100 && eraseBusy !== 1'b0; k++) @(negedge clk);
    if (k >= 2100) begin
      n_mismatch++;
      $display("unexpected erase end: expected 0, seen %b", eraseBusy);
      test_done();
    end
  endtask : erase_wait

  // ****
  // Scenarios
  // ****
  task automatic scen_erase_all_and_ids();
    i_prog.enter_mode();
    check("other logic reset", 14'h0001, {13'h0000, otherLogicReset});
    check("pin released in mode", 14'h0000, {13'h0000, dataOe});
    inc_n(513);
    erase_wait(1'b0);
    read_expect("erased user ID", 14'h0FFF);
    program_word(14'h3FF5);
    read_expect("user ID word", 14'h0FF5);
    inc_n(4);
    program_word(14'h00A5);
    read_expect("backup calibration", 14'h00A5);
  endtask : scen_erase_all_and_ids

  task automatic scen_protect_and_preserve();
    @(negedge clk);
    modeRequest = 1'b0;
    repeat (6) @(negedge clk);
    check("mode after exit", 14'h0000, {13'h0000, progModeActive});
    i_prog.enter_mode();
    read_expect("config word at entry", 14'h0FFF);
    erase_wait(1'b1);
    read_expect("config word after erase", 14'h0FFF);
    program_word(14'h0FF7);
    read_expect("protected config word", 14'h0FF7);
    inc_n(1);
    read_expect("low program word", 14'h0FFF);
    inc_n(64);
    read_expect("protected program word", 14'h0000);
    inc_n(447);
    program_word(14'h0C5A);
    read_expect("reset vector literal", 14'h0C5A);
    inc_n(1);
    read_expect("user ID under protection", 14'h0FF5);
    inc_n(4);
    read_expect("kept backup calibration", 14'h00A5);
    inc_n(60);
    read_expect("reserved config word", 14'h0000);
    inc_n(447);
    read_expect("config word after increment", 14'h0000);
  endtask : scen_protect_and_preserve

  initial begin
    reset = 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    scen_erase_all_and_ids();
    scen_protect_and_preserve();
    test_done();
  end
endmodule : serial_program_verify_port_tb
